// ### cycle_timer.sv
module cycle_timer #(
	parameter int W = 13
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         run,
	input  wire logic         load,
	input  wire logic [W-1:0] count,
	output logic              expire
);
	import ebi_ctl_pkg::*;

	typedef struct packed {
		logic [W-1:0] cnt;
	} timer_state_t;

	timer_state_t st_q;
	timer_state_t st_d;

	// Expire on the last cycle, so reloading then keeps the period exact
	assign expire = run && (st_q.cnt == W'(1));

	always_comb begin
		st_d = st_q;
		if (!run) begin
			st_d.cnt = '0;
		end else if (load) begin
			// Caller reloads on expire when it wants a periodic timer
			st_d.cnt = count;
		end else if (st_q.cnt != '0) begin
			st_d.cnt = st_q.cnt - W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

endmodule

// ### ebi_ctl.sv
module ebi_ctl (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [31:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output logic [31:0]                   prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic [1:0]               boot_width_strap,
	input  wire logic                     output_enable_n,
	input  wire logic [3:0]               byte_write_strobe_n,
	input  wire logic                     external_wait_n,
	input  wire logic [31:0]              mem_addr,
	input  wire logic                     page_access_start,
	output logic                          page_access_done,
	output logic [4:0]                    page_access_cycles,
	output ebi_ctl_pkg::sdram_ctl_t       sdram_ctl,
	output ebi_ctl_pkg::wait_result_t     wait_result,
	output ebi_ctl_pkg::rom_decode_t      rom_decode,
	output logic [2:0]                    io_byte_enable_mode,
	output logic [3:0]                    rom_access_cycles_code,
	output logic [1:0]                    rom_boot_width,
	output logic [1:0]                    rom_page_mode
);
	import ebi_ctl_pkg::*;

	typedef struct packed {
		logic [2:0]   exbe;
		logic         ref_act;
		logic         ref_mode;
		logic         cke_ctl;
		logic [12:0]  ref_cnt;
		logic [1:0]   wait_dly;
		logic [12:0]  base;
		logic [3:0]   size;
		logic [3:0]   page;
		logic [3:0]   acc;
		logic [1:0]   bootw;
		logic [1:0]   pgmode;
		logic         strap_taken;
		logic [31:0]  rdata;
		sdram_pwr_t   pwr;
		sdram_ctl_t   sd;
		logic         strobe_prev;
		logic [2:0]   wait_cnt;
		wait_result_t wres;
		rom_decode_t  dec;
		logic [4:0]   page_cyc;
		logic         page_done;
		logic         ref_was_run;
	} ctl_state_t;

	ctl_state_t st_q;
	ctl_state_t st_d;

	logic refresh_due;
	logic page_expire;
	logic ref_run;
	logic access;
	logic hit_bus;
	logic hit_rom;
	logic strobe_active;
	logic [5:0] size_info;

	// Little-endian flag is not stored, so no write can touch it
	function automatic logic [31:0] bus_word(input ctl_state_t s);
		logic [31:0] w;
		w = '0;
		w[EXBE_MSB:EXBE_LSB]         = s.exbe;
		w[REF_ACT_BIT]               = s.ref_act;
		w[REF_MODE_BIT]              = s.ref_mode;
		w[CKE_CTL_BIT]               = s.cke_ctl;
		w[REF_CNT_MSB:REF_CNT_LSB]   = s.ref_cnt;
		w[WAIT_DLY_MSB:WAIT_DLY_LSB] = s.wait_dly;
		w[LITTLE_BIT]                = 1'b1; // RULE_08
		return w;
	endfunction

	function automatic logic [31:0] rom_word(input ctl_state_t s);
		logic [31:0] w;
		w = '0;
		w[BASE_MSB:BASE_LSB]     = s.base;
		w[SIZE_MSB:SIZE_LSB]     = s.size;
		w[PAGE_MSB:PAGE_LSB]     = s.page;
		w[ACC_MSB:ACC_LSB]       = s.acc;
		w[BOOTW_MSB:BOOTW_LSB]   = s.bootw;
		w[PGMODE_MSB:PGMODE_LSB] = s.pgmode;
		return w;
	endfunction

	// Returns {valid, log2 of size in bytes}
	function automatic logic [5:0] size_decode(input logic [3:0] code, input logic [1:0] bw);
		logic [4:0] lg;
		logic       ok;
		lg = SIZE_LOG2_MIN + {2'h0, code[3:1]} + {1'b0, code[0], 3'h0}; // RULE_10
		ok = !code[0] || (code[3:1] < SIZE_HIGH_MAX) ||
			((code[3:1] == SIZE_HIGH_MAX) && (bw != BOOTW_32)); // RULE_10
		return {ok, lg};
	endfunction

	function automatic logic [4:0] page_decode(input logic [3:0] code);
		logic [4:0] c;
		if (code <= PAGE_LIN_MAX) begin
			c = {1'b0, code} + 5'h01; // RULE_11
		end else begin
			c = PAGE_STEP_BASE + {1'b0, code[2:0], 1'b0}; // RULE_11
		end
		return c;
	endfunction

	assign hit_bus = (paddr == BUS_CTL_ADDR);
	assign hit_rom = (paddr == ROM_CTL_ADDR);
	// No wait states; read data was captured in the setup cycle
	assign pready  = psel && penable;
	assign pslverr = psel && penable && !(hit_bus || hit_rom);
	assign access  = psel && penable && pready;
	assign prdata  = st_q.rdata;

	assign strobe_active = !output_enable_n || (byte_write_strobe_n != 4'hF);
	assign size_info     = size_decode(st_q.size, st_q.bootw);
	assign ref_run       = st_q.ref_act && (st_q.pwr == PWR_RUN); // RULE_05

	// One timer serves both banks since they share refresh timing
	cycle_timer #(
		.W (13)
	) u_refresh (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (ref_run), // RULE_05
		.load    (refresh_due || (ref_run && !st_q.ref_was_run)), // RULE_04
		.count   (st_q.ref_cnt), // RULE_03
		.expire  (refresh_due)
	);

	cycle_timer #(
		.W (5)
	) u_page (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (1'b1),
		.load    (page_access_start),
		.count   (st_q.page_cyc),
		.expire  (page_expire)
	);

	always_comb begin
		logic [32:0] start_ext;
		logic [32:0] offset;
		logic [32:0] span;
		start_ext = '0;
		offset    = '0;
		span      = '0;
		st_d      = st_q;

		// Register access
		if (psel && !penable) begin
			st_d.rdata = hit_bus ? bus_word(st_q) : (hit_rom ? rom_word(st_q) : 32'h0000_0000);
		end
		if (access && pwrite && hit_bus) begin
			st_d.exbe     = pwdata[EXBE_MSB:EXBE_LSB];
			st_d.ref_act  = pwdata[REF_ACT_BIT];
			st_d.ref_mode = pwdata[REF_MODE_BIT];
			st_d.cke_ctl  = pwdata[CKE_CTL_BIT];
			st_d.ref_cnt  = pwdata[REF_CNT_MSB:REF_CNT_LSB];
			st_d.wait_dly = pwdata[WAIT_DLY_MSB:WAIT_DLY_LSB];
		end
		if (access && pwrite && hit_rom) begin
			st_d.base   = pwdata[BASE_MSB:BASE_LSB];
			st_d.size   = pwdata[SIZE_MSB:SIZE_LSB];
			st_d.page   = pwdata[PAGE_MSB:PAGE_LSB];
			st_d.acc    = pwdata[ACC_MSB:ACC_LSB];
			st_d.bootw  = pwdata[BOOTW_MSB:BOOTW_LSB];
			st_d.pgmode = pwdata[PGMODE_MSB:PGMODE_LSB];
		end

		// Boot width strap caught once, the first edge after reset release
		if (!st_q.strap_taken) begin
			st_d.strap_taken = 1'b1;
			st_d.bootw       = boot_width_strap;
		end

		// SDRAM power state
		st_d.sd.self_refresh_entry = 1'b0;
		st_d.sd.self_refresh_exit  = 1'b0;
		unique case (st_q.pwr)
			PWR_RUN: begin
				if (st_q.ref_mode) begin
					st_d.pwr                   = PWR_SELF; // RULE_01
					st_d.sd.self_refresh_entry = 1'b1;
				end else if (!st_q.cke_ctl) begin
					st_d.pwr = PWR_DOWN; // RULE_02
				end
			end
			PWR_DOWN: begin
				if (st_q.ref_mode) begin
					st_d.pwr                   = PWR_SELF;
					st_d.sd.self_refresh_entry = 1'b1;
				end else if (st_q.cke_ctl) begin
					st_d.pwr = PWR_RUN; // RULE_02
				end
			end
			PWR_SELF: begin
				if (!st_q.ref_mode) begin
					st_d.pwr                  = st_q.cke_ctl ? PWR_RUN : PWR_DOWN; // RULE_01
					st_d.sd.self_refresh_exit = 1'b1;
				end
			end
			default: begin
				st_d.pwr = PWR_RUN;
			end
		endcase
		st_d.sd.cke = (st_d.pwr == PWR_RUN); // RULE_02
		// A refresh while CKE is low would be lost, so the timer only runs in the run state
		// Dropped when leaving the run state; self refresh covers it only on entry to PWR_SELF, not to PWR_DOWN
		st_d.sd.auto_refresh = refresh_due && (st_d.pwr == PWR_RUN); // RULE_04
		st_d.ref_was_run     = ref_run;

		// Wait sampling after a strobe goes active
		st_d.strobe_prev = strobe_active;
		st_d.wres.valid  = 1'b0;
		if (strobe_active && !st_q.strobe_prev) begin
			st_d.wait_cnt = {1'b0, st_q.wait_dly} + 3'h1; // RULE_07
		end else if (st_q.wait_cnt != 3'h0) begin
			st_d.wait_cnt = st_q.wait_cnt - 3'h1;
			if (st_q.wait_cnt == 3'h1) begin
				st_d.wres.valid = 1'b1; // RULE_06
				st_d.wres.stall = !external_wait_n; // RULE_06
			end
		end

		// ROM bank decode; base need not be aligned to size, hence the subtract
		start_ext        = {1'b0, 32'(st_q.base) << BASE_SHIFT}; // RULE_09
		offset           = {1'b0, mem_addr} - start_ext;
		span             = 33'h1 << size_info[4:0];
		st_d.dec.start   = start_ext[31:0];
		st_d.dec.size_error = !size_info[5];
		st_d.dec.hit     = size_info[5] && ({1'b0, mem_addr} >= start_ext) && (offset < span); // RULE_10

		// Page mode timing
		st_d.page_cyc  = page_decode(st_q.page); // RULE_11
		st_d.page_done = page_expire;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q          <= '0;
			st_q.exbe     <= BUS_CTL_RESET[EXBE_MSB:EXBE_LSB];
			st_q.ref_act  <= BUS_CTL_RESET[REF_ACT_BIT];
			st_q.ref_mode <= BUS_CTL_RESET[REF_MODE_BIT];
			st_q.cke_ctl  <= BUS_CTL_RESET[CKE_CTL_BIT]; // RULE_02
			st_q.ref_cnt  <= BUS_CTL_RESET[REF_CNT_MSB:REF_CNT_LSB];
			st_q.wait_dly <= BUS_CTL_RESET[WAIT_DLY_MSB:WAIT_DLY_LSB];
			st_q.base     <= ROM_CTL_RESET[BASE_MSB:BASE_LSB];
			st_q.size     <= ROM_CTL_RESET[SIZE_MSB:SIZE_LSB];
			st_q.page     <= ROM_CTL_RESET[PAGE_MSB:PAGE_LSB];
			st_q.acc      <= ROM_CTL_RESET[ACC_MSB:ACC_LSB];
			st_q.bootw    <= ROM_CTL_RESET[BOOTW_MSB:BOOTW_LSB];
			st_q.pgmode   <= ROM_CTL_RESET[PGMODE_MSB:PGMODE_LSB];
			st_q.pwr      <= PWR_RUN;
			st_q.sd.cke   <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign sdram_ctl              = st_q.sd;
	assign wait_result            = st_q.wres;
	assign rom_decode             = st_q.dec;
	assign page_access_cycles     = st_q.page_cyc;
	assign page_access_done       = st_q.page_done;
	assign io_byte_enable_mode    = st_q.exbe;
	assign rom_access_cycles_code = st_q.acc;
	assign rom_boot_width         = st_q.bootw;
	assign rom_page_mode          = st_q.pgmode;

endmodule

// ### ebi_ctl_pkg.sv
// How it works
// RULE_01: Refresh mode field: zero picks auto refresh, one picks self refresh.
// RULE_02: Clock-enable bit drives memory CKE; clear means power-down, set is reset default.
// RULE_03: Refresh interval field counts bus clocks between two refreshes.
// RULE_04: With refresh on, one auto-refresh issued per interval, no software help; the code issues none while in PWR_DOWN.
// RULE_05: Setting refresh activate starts periodic refresh for both SDRAM banks; the code runs it only in PWR_RUN.
// RULE_06: Wait input sampled on nth bus clock edge after strobe active cycle.
// RULE_07: Wait delay codes 00..11 select first to fourth rising edge.
// RULE_08: Endian flag bit zero is read-only and always reads one.
// RULE_09: ROM bank start address is base pointer shifted left by 18.
// RULE_10: Bank range is base plus coded size; reserved codes and 256M on 32-bit decode nothing.
// RULE_11: Page access code 0..7 gives 1..8 clocks, 8..15 gives 10..24 clocks.
package ebi_ctl_pkg;

	localparam logic [31:0] BUS_CTL_ADDR    = 32'hB000_1000;
	localparam logic [31:0] ROM_CTL_ADDR    = 32'hB000_1004;
	localparam logic [31:0] BUS_CTL_RESET   = 32'h0001_0001;
	localparam logic [31:0] ROM_CTL_RESET   = 32'h0000_0FF0;

	localparam int EXBE_LSB       = 24;
	localparam int EXBE_MSB       = 26;
	localparam int REF_ACT_BIT    = 18;
	localparam int REF_MODE_BIT   = 17;
	localparam int CKE_CTL_BIT    = 16;
	localparam int REF_CNT_LSB    = 3;
	localparam int REF_CNT_MSB    = 15;
	localparam int WAIT_DLY_LSB   = 1;
	localparam int WAIT_DLY_MSB   = 2;
	localparam int LITTLE_BIT     = 0;

	localparam int BASE_LSB       = 19;
	localparam int BASE_MSB       = 31;
	localparam int SIZE_LSB       = 15;
	localparam int SIZE_MSB       = 18;
	localparam int PAGE_LSB       = 8;
	localparam int PAGE_MSB       = 11;
	localparam int ACC_LSB        = 4;
	localparam int ACC_MSB        = 7;
	localparam int BOOTW_LSB      = 2;
	localparam int BOOTW_MSB      = 3;
	localparam int PGMODE_LSB     = 0;
	localparam int PGMODE_MSB     = 1;

	localparam int          BASE_SHIFT     = 18;
	localparam logic [4:0]  SIZE_LOG2_MIN  = 5'h12;
	localparam logic [2:0]  SIZE_HIGH_MAX  = 3'h2;
	localparam logic [1:0]  BOOTW_32       = 2'h2;
	localparam logic [3:0]  PAGE_LIN_MAX   = 4'h7;
	localparam logic [4:0]  PAGE_STEP_BASE = 5'h0A;

	typedef enum logic [1:0] {
		PWR_RUN,
		PWR_DOWN,
		PWR_SELF
	} sdram_pwr_t;

	typedef struct packed {
		logic cke;
		logic auto_refresh;
		logic self_refresh_entry;
		logic self_refresh_exit;
	} sdram_ctl_t;

	typedef struct packed {
		logic        hit;
		logic        size_error;
		logic [31:0] start;
	} rom_decode_t;

	typedef struct packed {
		logic valid;
		logic stall;
	} wait_result_t;

endpackage

// ### ebi_ctl_sva.sv
module ebi_ctl_sva
	import ebi_ctl_pkg::*;
(
	input wire logic                      pclk,
	input wire logic                      presetn,
	input wire logic                      psel,
	input wire logic                      penable,
	input wire logic                      pwrite,
	input wire logic [31:0]               paddr,
	input wire logic [31:0]               pwdata,
	input wire logic [31:0]               prdata,
	input wire logic                      pready,
	input wire logic                      pslverr,
	input wire logic                      output_enable_n,
	input wire logic [3:0]                byte_write_strobe_n,
	input wire logic                      external_wait_n,
	input wire logic [31:0]               mem_addr,
	input wire logic                      page_access_start,
	input wire logic                      page_access_done,
	input wire logic [4:0]                page_access_cycles,
	input wire ebi_ctl_pkg::sdram_ctl_t   sdram_ctl,
	input wire ebi_ctl_pkg::wait_result_t wait_result,
	input wire ebi_ctl_pkg::rom_decode_t  rom_decode
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic       acc;
	logic       strb;
	logic       wr_bus;
	logic [1:0] dly_q;
	assign acc = psel && penable;
	assign strb = !output_enable_n || (byte_write_strobe_n != 4'hF);
	assign wr_bus = acc && pwrite && (paddr == BUS_CTL_ADDR);
	// Shadow of the wait delay code, seen only through bus writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly_q <= 2'h0;
		end else if (wr_bus) begin
			dly_q <= pwdata[2:1];
		end
	end
	property p_unmapped;
		acc && paddr != BUS_CTL_ADDR && paddr != ROM_CTL_ADDR |-> pready && pslverr && (pwrite || prdata == 32'h0);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_little;
		acc && !pwrite && paddr == BUS_CTL_ADDR |-> prdata[0];
	endproperty
	a_little: assert property (p_little) else $error("endian flag reads zero");
	property p_cke_off;
		wr_bus && !pwdata[17] && !pwdata[16] |-> ##2 !sdram_ctl.cke;
	endproperty
	a_cke_off: assert property (p_cke_off) else $error("clock enable still high");
	property p_self;
		wr_bus && pwdata[17] |-> ##2 !sdram_ctl.cke ##1 !sdram_ctl.auto_refresh [*8];
	endproperty
	a_self: assert property (p_self) else $error("self refresh not entered");
	property p_ref_cke;
		sdram_ctl.auto_refresh |-> sdram_ctl.cke;
	endproperty
	a_ref_cke: assert property (p_ref_cke) else $error("refresh issued in power down");
	property p_wait4;
		strb && !$past(strb) && dly_q == 2'h3 |-> !wait_result.valid [*5] ##1 wait_result.valid;
	endproperty
	a_wait4: assert property (p_wait4) else $error("fourth edge sample misplaced");
	property p_stall;
		wait_result.valid |-> wait_result.stall == !$past(external_wait_n);
	endproperty
	a_stall: assert property (p_stall) else $error("stall not the sampled wait");
	property p_page1;
		page_access_start && page_access_cycles == 5'h01 |-> ##2 page_access_done;
	endproperty
	a_page1: assert property (p_page1) else $error("one clock page access late");
	property p_rom;
		rom_decode.hit |-> $past(mem_addr) >= rom_decode.start && rom_decode.start[17:0] == 18'h0;
	endproperty
	a_rom: assert property (p_rom) else $error("hit below bank start");
endmodule
bind ebi_ctl ebi_ctl_sva chk_u (
	.pclk                (pclk),
	.presetn             (presetn),
	.psel                (psel),
	.penable             (penable),
	.pwrite              (pwrite),
	.paddr               (paddr),
	.pwdata              (pwdata),
	.prdata              (prdata),
	.pready              (pready),
	.pslverr             (pslverr),
	.output_enable_n     (output_enable_n),
	.byte_write_strobe_n (byte_write_strobe_n),
	.external_wait_n     (external_wait_n),
	.mem_addr            (mem_addr),
	.page_access_start   (page_access_start),
	.page_access_done    (page_access_done),
	.page_access_cycles  (page_access_cycles),
	.sdram_ctl           (sdram_ctl),
	.wait_result         (wait_result),
	.rom_decode          (rom_decode)
);

// ### ext_dev.sv
module ext_dev (
	input  wire logic pclk,
	input  wire logic strobe_n,
	input  wire logic stall_en,
	output logic      wait_n
);
	timeunit 1ns;
	timeprecision 1ps;
	initial wait_n = 1'b1;
	// Pulled up line: deselected device reads ready, slow one holds it low
	always @(posedge pclk) begin
		wait_n <= !(!strobe_n && stall_en);
	end
endmodule

// ### testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import ebi_ctl_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, perr;
	logic [31:0] paddr = 0, pwdata = 0, prdata, rdat, mem_addr = 0;
	logic output_enable_n = 1, external_wait_n, page_access_start = 0, page_access_done, stall_en = 0;
	logic [3:0] byte_write_strobe_n = 4'hF;
	logic [4:0] page_access_cycles;
	logic [2:0] io_mode;
	logic [3:0] acc_code;
	logic [1:0] boot_w, pg_mode;
	sdram_ctl_t sdram_ctl;
	wait_result_t wait_result;
	rom_decode_t rom_decode;
	int fail_count = 0, total_checks = 0, cyc = 0, n;
	int pc[4] = '{0, 7, 8, 15};
	int pe[4] = '{1, 8, 10, 24};
	always #5 pclk = ~pclk;
	ebi_ctl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.boot_width_strap(2'h1), .output_enable_n(output_enable_n), .byte_write_strobe_n(byte_write_strobe_n),
		.external_wait_n(external_wait_n), .mem_addr(mem_addr), .page_access_start(page_access_start),
		.page_access_done(page_access_done), .page_access_cycles(page_access_cycles), .sdram_ctl(sdram_ctl),
		.wait_result(wait_result), .rom_decode(rom_decode), .io_byte_enable_mode(io_mode),
		.rom_access_cycles_code(acc_code), .rom_boot_width(boot_w), .rom_page_mode(pg_mode));
	ext_dev dev_u (.pclk(pclk), .strobe_n(output_enable_n & (&byte_write_strobe_n)), .stall_en(stall_en),
		.wait_n(external_wait_n));
	task automatic complete_run();
		if (fail_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench timeout ends a wait for pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic flag(input int w);
		case (w)
			0: return sdram_ctl.auto_refresh;
			1: return wait_result.valid;
			default: return page_access_done;
		endcase
	endfunction
	// Counts falling edges so outputs are read settled
	task automatic gap(input int w, output int k);
		k = 0;
		do begin
			@(negedge pclk);
			k++;
		end while (flag(w) !== 1'b1 && k < 200);
	endtask
	task automatic dec(input logic [31:0] a, input logic h);
		@(posedge pclk);
		mem_addr <= a;
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		check("rom_hit", rom_decode.hit, h);
		check("rom_start", rom_decode.start, 32'h000C_0000);
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			complete_run();
		end
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, BUS_CTL_ADDR, 0, rdat);
		check("bus_reset", rdat, BUS_CTL_RESET);
		apb(0, ROM_CTL_ADDR, 0, rdat);
		check("rom_reset", rdat, ROM_CTL_RESET | 32'h4);
		check("boot_width", boot_w, 2'h1);
		apb(0, 32'hB000_1008, 0, rdat);
		check("unmapped", {perr, rdat[30:0]}, 32'h8000_0000);
		apb(1, BUS_CTL_ADDR, 0, rdat);
		apb(0, BUS_CTL_ADDR, 0, rdat);
		check("little", rdat, 32'h1);
		check("cke_off", sdram_ctl.cke, 0);
		apb(1, BUS_CTL_ADDR, 32'h0005_0028, rdat);
		gap(0, n);
		gap(0, n);
		check("ref_period", n, 5);
		apb(1, BUS_CTL_ADDR, 32'h0007_0028, rdat);
		repeat (2) @(negedge pclk);
		check("sr_entry", sdram_ctl.self_refresh_entry, 1);
		@(negedge pclk);
		check("self_cke", sdram_ctl.cke, 0);
		gap(0, n);
		check("self_quiet", n, 200);
		apb(1, BUS_CTL_ADDR, 32'h0001_0000, rdat);
		repeat (2) @(negedge pclk);
		check("sr_exit", sdram_ctl.self_refresh_exit, 1);
		check("run_cke", sdram_ctl.cke, 1);
		for (int c = 0; c < 4; c++) begin
			apb(1, BUS_CTL_ADDR, 32'h0001_0000 | (c << 1), rdat);
			stall_en <= c[0];
			@(posedge pclk);
			if (c == 3) byte_write_strobe_n <= 4'hE;
			else output_enable_n <= 1'b0;
			gap(1, n);
			check("wait_edge", n, c + 3);
			check("stall", wait_result.stall, c[0]);
			@(posedge pclk);
			output_enable_n <= 1'b1;
			byte_write_strobe_n <= 4'hF;
		end
		apb(1, ROM_CTL_ADDR, 32'h0018_0000, rdat);
		dec(32'h000C_0000, 1);
		dec(32'h000F_FFFF, 1);
		dec(32'h0010_0000, 0);
		dec(32'h000B_FFFF, 0);
		apb(1, ROM_CTL_ADDR, 32'h001F_8000, rdat);
		dec(32'h000C_0000, 0);
		check("size_err", rom_decode.size_error, 1);
		apb(1, ROM_CTL_ADDR, 32'h001A_8008, rdat);
		dec(32'h000C_0000, 0);
		check("size_256m_w32", rom_decode.size_error, 1);
		apb(1, ROM_CTL_ADDR, 32'h001A_8004, rdat);
		dec(32'h000C_0000, 1);
		check("size_256m_w16", rom_decode.size_error, 0);
		foreach (pc[i]) begin
			apb(1, ROM_CTL_ADDR, pc[i] << 8, rdat);
			@(posedge pclk);
			page_access_start <= 1'b1;
			@(posedge pclk);
			page_access_start <= 1'b0;
			gap(2, n);
			check("page_cycles", page_access_cycles, pe[i]);
			check("page_done", n, pe[i] + 1);
		end
		apb(1, BUS_CTL_ADDR, 32'h0701_0000, rdat);
		apb(1, ROM_CTL_ADDR, 32'h0000_00AB, rdat);
		apb(0, ROM_CTL_ADDR, 0, rdat);
		check("rom_fields", rdat, 32'h0000_00AB);
		check("io_mode", io_mode, 3'h7);
		check("acc_code", acc_code, 4'hA);
		check("boot_w", boot_w, 2'h2);
		check("pg_mode", pg_mode, 2'h3);
		complete_run();
	end
endmodule
